// ==== lhp_device.sv ====
// LCD controller end of the host interface port.
// Assumes the host makes the strobe/shift clock and keeps transfers spaced
// so the core-side shadows stay still while the host reads them.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_device (
    // System clock and reset
    input  wire logic       MCLK_IN,
    input  wire logic       RST_N_IN,
    // Link to the host
    lhp_link_if.dev         LNK,
    // Core status and read data
    input  wire logic       BUSY_IN,
    input  wire logic [6:0] ADDR_CNT_IN,
    input  wire logic [7:0] RD_DATA_IN,
    input  wire logic       WIDTH4_IN,
    // Core strobes and write data
    output logic            INSTR_WR_OUT,
    output logic            DATA_WR_OUT,
    output logic [7:0]      WR_BYTE_OUT,
    output logic            DATA_RD_OUT,
    // Clock monitor
    output logic            CLK_MON_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    lhp_pkg::lhp_byte_t stat_r;
    lhp_pkg::lhp_byte_t dat_r;
    logic               wide4_r;
    logic               mon_r;
    logic [2:0]         bit_cnt_r;
    logic [6:0]         shift_r;
    logic               nib_r;
    logic [3:0]         hi_nib_r;
    logic [8:0]         hold_r;
    logic               wr_tog_r;
    logic               rd_tog_r;
    logic [2:0]         wr_sync_r;
    logic [2:0]         rd_sync_r;
    logic               cs;
    logic               done;
    lhp_pkg::lhp_byte_t word;
    lhp_pkg::lhp_byte_t rd_word;

    // ------------------------------------------------------------
    // System clock side: shadows and monitor
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            stat_r  <= 8'h00;
            dat_r   <= 8'h00;
            wide4_r <= 1'b0;
        end else begin
            stat_r  <= {BUSY_IN, ADDR_CNT_IN}; // R9 R3
            dat_r   <= RD_DATA_IN;
            wide4_r <= WIDTH4_IN;
        end
    end

    // Whatever clock drives MCLK_IN, internal or applied, runs the core
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mon_r <= 1'b0;
        end else begin
            mon_r <= ~mon_r; // R13
        end
    end

    assign CLK_MON_OUT = mon_r; // R14

    // ------------------------------------------------------------
    // Link side: frame decode
    // ------------------------------------------------------------
    assign cs = LNK.db[`LHP_BIT_CS]; // R7

    always_comb begin
        word = LNK.db;
        done = 1'b0;
        if (LNK.mode_par) begin // R1
            if (wide4_r) begin
                word = {hi_nib_r, LNK.db[7:4]}; // R15
                done = nib_r;
            end else begin
                done = 1'b1; // R5
            end
        end else begin
            word = {shift_r, LNK.db[`LHP_BIT_SDAT]}; // R8
            done = cs && (bit_cnt_r == 3'h7);
        end
    end

    // Nibble phase, only in half-width parallel mode
    always_ff @(posedge LNK.link_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            nib_r    <= 1'b0;
            hi_nib_r <= 4'h0;
        end else if (LNK.mode_par && wide4_r) begin
            nib_r <= ~nib_r; // R15
            if (!nib_r) begin
                hi_nib_r <= LNK.db[7:4];
            end
        end
    end

    // Serial shift; edges without chip select are ignored
    always_ff @(posedge LNK.link_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else if (!LNK.mode_par && cs) begin // R6 R7
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= {shift_r[5:0], LNK.db[`LHP_BIT_SDAT]}; // R8
        end
    end

    // Completed transfer handed to the core by toggle
    always_ff @(posedge LNK.link_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hold_r   <= 9'h000;
            wr_tog_r <= 1'b0;
            rd_tog_r <= 1'b0;
        end else if (done) begin
            if (!LNK.rd_nwr) begin // R4
                hold_r   <= {LNK.reg_sel, word}; // R2
                wr_tog_r <= ~wr_tog_r;
            end else if (LNK.reg_sel) begin
                rd_tog_r <= ~rd_tog_r; // R2
            end
        end
    end

    // ------------------------------------------------------------
    // Link side: read drive
    // ------------------------------------------------------------
    assign rd_word = LNK.reg_sel ? dat_r : stat_r; // R2 R3

    always_comb begin
        LNK.db_d_o  = 8'h00;
        LNK.db_d_oe = 8'h00; // R12
        if (LNK.rd_nwr) begin
            if (LNK.mode_par) begin
                if (LNK.link_clk) begin // R5 R12
                    if (wide4_r) begin
                        // Phase has already flipped at this strobe's rising edge
                        LNK.db_d_o  = lhp_pkg::lhp_nib(rd_word, nib_r); // R15
                        LNK.db_d_oe = `LHP_MASK_HIGH; // R10
                    end else begin
                        LNK.db_d_o  = rd_word; // R9
                        LNK.db_d_oe = `LHP_MASK_ALL;
                    end
                end
            end else if (cs) begin
                LNK.db_d_o[`LHP_BIT_SDAT] = rd_word[3'h7 - bit_cnt_r]; // R8
                LNK.db_d_oe = `LHP_MASK_SDAT; // R10 R11
            end
        end
    end

    // ------------------------------------------------------------
    // System clock side: toggle receivers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_sync_r <= 3'h0;
            rd_sync_r <= 3'h0;
        end else begin
            wr_sync_r <= {wr_sync_r[1:0], wr_tog_r};
            rd_sync_r <= {rd_sync_r[1:0], rd_tog_r};
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            INSTR_WR_OUT <= 1'b0;
            DATA_WR_OUT  <= 1'b0;
            WR_BYTE_OUT  <= 8'h00;
            DATA_RD_OUT  <= 1'b0;
        end else begin
            INSTR_WR_OUT <= 1'b0;
            DATA_WR_OUT  <= 1'b0;
            DATA_RD_OUT  <= rd_sync_r[2] ^ rd_sync_r[1];
            if (wr_sync_r[2] ^ wr_sync_r[1]) begin
                WR_BYTE_OUT  <= hold_r[7:0];
                INSTR_WR_OUT <= ~hold_r[8]; // R2
                DATA_WR_OUT  <= hold_r[8];
            end
        end
    end

endmodule

// ==== lhp_defs.svh ====
// Constants for the LCD host interface port: offsets, fields, resets, timing.
// Assumes the includer supplies the timescale; definitions only.
//
// How it works
// R1: Strap low serial, high parallel
// R2: Select low writes instruction, high data
// R3: Select low read gives busy, address
// R4: R/W low write, high read
// R5: Parallel access only on strobe
// R6: Serial mode strobe is shift clock
// R7: Bit seven is serial chip select
// R8: Bit six is serial data line
// R9: Busy flag on bit seven
// R10: Low nibble unused in serial, 4-bit
// R11: Bits four, five unused in serial
// R12: Bus driven only during reads
// R13: Runs from supplied system clock
// R14: System clock shown on monitor output; the code shows MCLK_IN divided by two
// R15: 4-bit mode: high nibble first
// R16: Host waits for busy before next
`ifndef LHP_DEFS_SVH
`define LHP_DEFS_SVH

// ----------------------------------------------------------------
// Host command port map
// ----------------------------------------------------------------
`define LHP_ADDR_CTRL    4'h0
`define LHP_ADDR_CMD     4'h4
`define LHP_ADDR_STAT    4'h8

`define LHP_CTRL_PAR_BIT 0
`define LHP_CTRL_W4_BIT  1
`define LHP_CTRL_RESET   2'h1
`define LHP_CMD_SEL_BIT  8
`define LHP_CMD_RW_BIT   9
`define LHP_STAT_BUSY    0
`define LHP_STAT_RX_LSB  8

// ----------------------------------------------------------------
// Pin masks
// ----------------------------------------------------------------
`define LHP_MASK_ALL     8'hff
`define LHP_MASK_HIGH    8'hf0
`define LHP_MASK_CS      8'h80
`define LHP_MASK_CS_SDAT 8'hc0
`define LHP_MASK_SDAT    8'h40
`define LHP_BIT_CS       7
`define LHP_BIT_SDAT     6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LHP_MCLK_KHZ     25000
`define LHP_HALF_NS      500
`define LHP_HALF_CYC     ((`LHP_HALF_NS * `LHP_MCLK_KHZ + 999999) / 1000000)

`endif

// ==== lhp_pkg.sv ====
// Types and helpers shared by both ends of the LCD host interface port.
// Assumes nothing of its surroundings.
package lhp_pkg;

    typedef logic [7:0] lhp_byte_t;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_SETUP = 2'b01,
        HS_HIGH  = 2'b10
    } lhp_hstate_t;

    // Nibble on bits 7:4 of a half-width transfer
    function automatic lhp_byte_t lhp_nib(input lhp_byte_t b, input logic hi);
        lhp_nib = hi ? {b[7:4], 4'h0} : {b[3:0], 4'h0};
    endfunction

endpackage

// ==== lhp_link_if.sv ====
// Pins between host and LCD controller, with the shared bus resolved.
// Assumes each end drives only its own output and enable signals.
`timescale 1ns/1ps
interface lhp_link_if;
    logic       mode_par;
    logic       reg_sel;
    logic       rd_nwr;
    logic       link_clk;
    logic [7:0] db_h_o;
    logic [7:0] db_h_oe;
    logic [7:0] db_d_o;
    logic [7:0] db_d_oe;
    logic [7:0] db;

    // Device drive wins; an undriven bit reads low
    assign db = (db_d_oe & db_d_o) | (~db_d_oe & db_h_oe & db_h_o);

    modport dev (
        input  mode_par,
        input  reg_sel,
        input  rd_nwr,
        input  link_clk,
        input  db,
        output db_d_o,
        output db_d_oe
    );

    modport host (
        output mode_par,
        output reg_sel,
        output rd_nwr,
        output link_clk,
        output db_h_o,
        output db_h_oe,
        input  db
    );
endinterface

// ==== lhp_host.sv ====
// Host end of the LCD host interface port, driven through a command port.
// Assumes the device follows the same pin use; strobe made by divider.
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_host (
    // System clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    // Command port
    input  wire logic [3:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic [31:0]      RDATA_OUT,
    // Link to the device
    lhp_link_if.host         LNK
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [7:0] HALF = 8'(`LHP_HALF_CYC);

    lhp_pkg::lhp_hstate_t st_r;
    logic [1:0]           ctrl_r;
    logic                 sel_r;
    logic                 rw_r;
    lhp_pkg::lhp_byte_t   tx_r;
    lhp_pkg::lhp_byte_t   rx_r;
    logic [7:0]           tick_r;
    logic [2:0]           pcnt_r;
    logic                 clk_r;
    logic [7:0]           db_s1_r;
    logic [7:0]           db_s2_r;
    logic [2:0]           last;
    logic                 cmd_go;
    logic                 tick_end;

    assign cmd_go   = WR_IN && (ADDR_IN == `LHP_ADDR_CMD) && (st_r == lhp_pkg::HS_IDLE);
    assign tick_end = (tick_r == HALF - 8'h01);

    always_comb begin
        if (!ctrl_r[`LHP_CTRL_PAR_BIT]) begin
            last = 3'h7;
        end else if (ctrl_r[`LHP_CTRL_W4_BIT]) begin
            last = 3'h1; // R15
        end else begin
            last = 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Command port registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_r <= `LHP_CTRL_RESET;
            sel_r  <= 1'b0;
            rw_r   <= 1'b0;
            tx_r   <= 8'h00;
        end else if (WR_IN && st_r == lhp_pkg::HS_IDLE) begin // R16
            if (ADDR_IN == `LHP_ADDR_CTRL) begin
                ctrl_r <= WDATA_IN[1:0];
            end else if (ADDR_IN == `LHP_ADDR_CMD) begin
                sel_r <= WDATA_IN[`LHP_CMD_SEL_BIT];
                rw_r <= WDATA_IN[`LHP_CMD_RW_BIT];
                tx_r <= WDATA_IN[7:0];
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT <= 32'h0;
        end else if (RD_IN && ADDR_IN == `LHP_ADDR_CTRL) begin
            RDATA_OUT <= {30'h0, ctrl_r};
        end else if (RD_IN && ADDR_IN == `LHP_ADDR_STAT) begin
            RDATA_OUT <= {16'h0, rx_r, 7'h0, st_r != lhp_pkg::HS_IDLE};
        end else begin
            RDATA_OUT <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Strobe sequencer
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_r   <= lhp_pkg::HS_IDLE;
            tick_r <= 8'h00;
            pcnt_r <= 3'h0;
            clk_r  <= 1'b0;
        end else begin
            case (st_r)
                lhp_pkg::HS_IDLE: begin
                    tick_r <= 8'h00;
                    pcnt_r <= 3'h0;
                    if (cmd_go) begin
                        st_r <= lhp_pkg::HS_SETUP;
                    end
                end
                lhp_pkg::HS_SETUP: begin
                    tick_r <= tick_end ? 8'h00 : tick_r + 8'h01;
                    if (tick_end) begin
                        st_r  <= lhp_pkg::HS_HIGH;
                        clk_r <= 1'b1; // R5 R6
                    end
                end
                lhp_pkg::HS_HIGH: begin
                    tick_r <= tick_end ? 8'h00 : tick_r + 8'h01;
                    if (tick_end) begin
                        clk_r <= 1'b0;
                        if (pcnt_r == last) begin
                            st_r <= lhp_pkg::HS_IDLE;
                        end else begin
                            pcnt_r <= pcnt_r + 3'h1;
                            st_r   <= lhp_pkg::HS_SETUP;
                        end
                    end
                end
                default: begin
                    st_r <= lhp_pkg::HS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read sampling
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            db_s1_r <= 8'h00;
            db_s2_r <= 8'h00;
            rx_r    <= 8'h00;
        end else begin
            db_s1_r <= LNK.db;
            db_s2_r <= db_s1_r;
            if (rw_r && tick_end) begin
                if (!ctrl_r[`LHP_CTRL_PAR_BIT] && st_r == lhp_pkg::HS_SETUP) begin
                    rx_r <= {rx_r[6:0], db_s2_r[`LHP_BIT_SDAT]}; // R8
                end else if (ctrl_r[`LHP_CTRL_PAR_BIT] && st_r == lhp_pkg::HS_HIGH) begin
                    if (ctrl_r[`LHP_CTRL_W4_BIT]) begin
                        rx_r <= {rx_r[3:0], db_s2_r[7:4]}; // R15
                    end else begin
                        rx_r <= db_s2_r;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign LNK.mode_par = ctrl_r[`LHP_CTRL_PAR_BIT]; // R1
    assign LNK.reg_sel  = sel_r;
    assign LNK.rd_nwr   = rw_r; // R4
    assign LNK.link_clk = clk_r;

    always_comb begin
        LNK.db_h_o  = 8'h00;
        LNK.db_h_oe = 8'h00;
        if (st_r != lhp_pkg::HS_IDLE) begin
            if (!ctrl_r[`LHP_CTRL_PAR_BIT]) begin
                LNK.db_h_o[`LHP_BIT_CS]  = 1'b1; // R7
                LNK.db_h_o[`LHP_BIT_SDAT] = tx_r[3'h7 - pcnt_r];
                LNK.db_h_oe = rw_r ? `LHP_MASK_CS : `LHP_MASK_CS_SDAT; // R10 R11
            end else if (!rw_r) begin
                if (ctrl_r[`LHP_CTRL_W4_BIT]) begin
                    LNK.db_h_o  = lhp_pkg::lhp_nib(tx_r, pcnt_r == 3'h0); // R15
                    LNK.db_h_oe = `LHP_MASK_HIGH; // R10
                end else begin
                    LNK.db_h_o  = tx_r;
                    LNK.db_h_oe = `LHP_MASK_ALL;
                end
            end
        end
    end

endmodule

// ==== lhp_link_monitor.sv ====
// Link checker for the LCD host interface port, watching both ends.
// Assumes the strobe is made from MCLK_IN by the host end.
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_link_monitor (
    // System clock and reset
    input  wire logic       MCLK_IN,
    input  wire logic       RST_N_IN,
    // Link signals
    input  wire logic       mode_par,
    input  wire logic       reg_sel,
    input  wire logic       rd_nwr,
    input  wire logic       link_clk,
    input  wire logic [7:0] db_h_o,
    input  wire logic [7:0] db_h_oe,
    input  wire logic [7:0] db_d_oe,
    input  wire logic [7:0] db
);
    logic [7:0] hi_cnt_r;

    // ------------------------------------------------------------
    // Strobe high-time counter
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hi_cnt_r <= 8'h00;
        end else begin
            hi_cnt_r <= link_clk ? hi_cnt_r + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ------------------------------------------------------------
    // Link assertions
    // ------------------------------------------------------------
    a_dev_read_only: assert property (|db_d_oe |-> rd_nwr)
        else $error("device drives bus outside a read");
    a_host_read_off: assert property (mode_par && rd_nwr && link_clk |-> db_h_oe == 8'h00)
        else $error("host drives bus during parallel read");
    a_par_dev_width: assert property (mode_par && |db_d_oe |-> db_d_oe inside {8'hff, 8'hf0})
        else $error("device read width wrong");
    a_ser_dev_sio: assert property (!mode_par |-> (db_d_oe & 8'hbf) == 8'h00)
        else $error("device drives a pin other than serial data");
    a_ser_host_pins: assert property (!mode_par |-> (db_h_oe & 8'h3f) == 8'h00)
        else $error("host drives an unused pin in serial mode");
    a_ser_cs_edge: assert property (!mode_par && $rose(link_clk) |-> db_h_oe[7] && db_h_o[7] && db[7])
        else $error("shift clock edge without chip select");
    a_strobe_width: assert property ($fell(link_clk) |-> hi_cnt_r == 8'(`LHP_HALF_CYC))
        else $error("strobe high time wrong");
    a_ctl_stable_high: assert property (link_clk && $past(link_clk) |->
        $stable(reg_sel) && $stable(rd_nwr) && $stable(mode_par))
        else $error("control lines move while strobe high");

    c_par8_read: cover property (mode_par && db_d_oe == 8'hff);
    c_par4_read: cover property (mode_par && db_d_oe == 8'hf0);
    c_ser_read: cover property (!mode_par && db_d_oe[6]);
    c_ser_write: cover property (!mode_par && $rose(link_clk) && !rd_nwr);
endmodule

// ==== tb_top.sv ====
// Testbench joining the host and device ends of the LCD host interface port.
// Assumes the host command port map and link timing of lhp_defs.svh.
`timescale 1ns/1ps
`include "lhp_defs.svh"
module tb_top;
    logic               mclk_in;
    logic               rst_n_in;
    logic [3:0]         addr_in;
    logic [31:0]        wdata_in;
    logic               wr_in;
    logic               rd_in;
    logic [31:0]        rdata_out;
    logic               busy_in;
    logic [6:0]         addr_cnt_in;
    logic [7:0]         rd_data_in;
    logic               width4_in;
    logic               instr_wr_out;
    logic               data_wr_out;
    logic [7:0]         wr_byte_out;
    logic               data_rd_out;
    logic               clk_mon_out;
    int                 error_cnt = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    int                 n_instr = 0;
    int                 n_data = 0;
    int                 n_rd = 0;
    lhp_pkg::lhp_byte_t last_wr;
    logic [1:0]         ctrl_tab [3] = '{2'h1, 2'h3, 2'h0};

    lhp_link_if lhp_link_if_inst ();
    lhp_host lhp_host_inst (.MCLK_IN(mclk_in), .RST_N_IN(rst_n_in), .ADDR_IN(addr_in),
        .WDATA_IN(wdata_in), .WR_IN(wr_in), .RD_IN(rd_in), .RDATA_OUT(rdata_out),
        .LNK(lhp_link_if_inst));
    lhp_device lhp_device_inst (.MCLK_IN(mclk_in), .RST_N_IN(rst_n_in),
        .LNK(lhp_link_if_inst), .BUSY_IN(busy_in), .ADDR_CNT_IN(addr_cnt_in),
        .RD_DATA_IN(rd_data_in), .WIDTH4_IN(width4_in), .INSTR_WR_OUT(instr_wr_out),
        .DATA_WR_OUT(data_wr_out), .WR_BYTE_OUT(wr_byte_out), .DATA_RD_OUT(data_rd_out),
        .CLK_MON_OUT(clk_mon_out));
    lhp_link_monitor lhp_link_monitor_inst (.MCLK_IN(mclk_in), .RST_N_IN(rst_n_in),
        .mode_par(lhp_link_if_inst.mode_par), .reg_sel(lhp_link_if_inst.reg_sel),
        .rd_nwr(lhp_link_if_inst.rd_nwr), .link_clk(lhp_link_if_inst.link_clk),
        .db_h_o(lhp_link_if_inst.db_h_o), .db_h_oe(lhp_link_if_inst.db_h_oe),
        .db_d_oe(lhp_link_if_inst.db_d_oe), .db(lhp_link_if_inst.db));

    // ------------------------------------------------------------
    // Clock, pulse capture and hang guard
    // ------------------------------------------------------------
    initial mclk_in = 1'b0;
    always #20 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        if (instr_wr_out === 1'b1) begin
            n_instr++;
            last_wr = wr_byte_out;
        end
        if (data_wr_out === 1'b1) begin
            n_data++;
            last_wr = wr_byte_out;
        end
        if (data_rd_out === 1'b1) begin
            n_rd++;
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Command port tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in   <= 1'b0;
        // Data stand in the cycle after the strobe; taken at its closing edge
        @(posedge mclk_in);
        v = rdata_out;
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        for (int k = 0; k < 500; k++) begin
            rd(`LHP_ADDR_STAT, s);
            if (s[0] === 1'b0) break;
        end
        repeat (6) @(posedge mclk_in);
    endtask

    task automatic xfer(input logic sel, input logic rw, input logic [7:0] b);
        n_instr = 0;
        n_data  = 0;
        n_rd    = 0;
        wr(`LHP_ADDR_CMD, {22'h0, rw, sel, b});
        wait_idle();
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence: every mode, every register and direction
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [7:0]  b;
        logic [7:0]  nb;
        logic [6:0]  ac;
        logic        c0;
        logic        c1;
        rst_n_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        busy_in = 1'b0;
        addr_cnt_in = 7'h00;
        rd_data_in = 8'h00;
        width4_in = 1'b0;
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(`LHP_ADDR_CTRL, d);
        chk("ctrl reset", d, 32'h1);
        for (int m = 0; m < 3; m++) begin
            wr(`LHP_ADDR_CTRL, {30'h0, ctrl_tab[m]});
            width4_in <= ctrl_tab[m][1];
            rd(`LHP_ADDR_CTRL, d);
            chk("ctrl mode", d, {30'h0, ctrl_tab[m]});
            b  = 8'h81 + 8'(m);
            nb = ~b;
            ac = 7'h35 + 7'(m);
            xfer(1'b0, 1'b0, b);
            chk("instr pulses", n_instr, 1);
            chk("instr byte", last_wr, b);
            xfer(1'b1, 1'b0, nb);
            chk("data pulses", n_data, 1);
            chk("stray instr", n_instr, 0);
            chk("data byte", last_wr, nb);
            busy_in     <= m[0];
            addr_cnt_in <= ac;
            xfer(1'b0, 1'b1, 8'h00);
            rd(`LHP_ADDR_STAT, d);
            chk("status byte", d[15:8], {m[0], ac});
            chk("status no data read", n_rd, 0);
            rd_data_in <= 8'ha6 ^ 8'(m);
            xfer(1'b1, 1'b1, 8'h00);
            rd(`LHP_ADDR_STAT, d);
            chk("data read byte", d[15:8], 8'ha6 ^ 8'(m));
            chk("data read pulses", n_rd, 1);
            $display("test mode %0d done", m);
        end
        n_data = 0;
        wr(`LHP_ADDR_CMD, {22'h0, 2'b01, 8'h5e});
        wr(`LHP_ADDR_CTRL, 32'h1);
        wait_idle();
        rd(`LHP_ADDR_CTRL, d);
        chk("ctrl kept while busy", d, 32'h0);
        chk("serial data byte", last_wr, 8'h5e);
        rd(4'hc, d);
        chk("unmapped read", d, 32'h0);
        @(posedge mclk_in);
        #1;
        c0 = clk_mon_out;
        c1 = ~c0;
        @(posedge mclk_in);
        #1;
        chk("clock monitor", clk_mon_out, c1);
        $display("test refusal and monitor done");
        test_done();
    end
endmodule
